//--- rtl/vlfm_pkg.sv
/*
 * Shared constants and types of the output-voltage limit and undervoltage fault monitor.
 * It assumes a 50 MHz system clock and a command engine that decodes host transfers
 * into one-cycle read and write strobes carrying the command code.
 */
// Notes on behaviour
// - Sample above high warning threshold sets output and warning status, asserts alert.
// - A very fast swing into overvoltage may skip the high warning record.
// - Overvoltage retry waits until output falls below the high warning threshold.
// - Thresholds are 16-bit unsigned codes, volts equal code times 2 to -13.
// - Low warning and low fault detection masked while ramping, not good, disabled.
// - Sample below low warning threshold sets output and warning status, asserts alert.
// - Sample below low fault threshold sets output and fault status, asserts alert.
// - Action mode 10 means disable then retry per retry field; others unused.
// - Low fault asserts alert and sets a fault bit kept until clear.
// - Retry field 000 keeps output off after fault until faults are cleared.
// - Retry fields 001 to 111 retry forever until off, bias loss, other fault.
// - Retry spacing is (delay field plus one) times 35 ms from fault or attempt.
// - Each retry still waits the turn-on delay before enabling the output.
// - Thresholds load as 1.08, 0.9 and 0.85 times the strapped setpoint.
// - Low fault action byte loads from the configuration strap at power-up.
package vlfm_pkg;
    localparam logic [7:0] CMD_OV_WARN = 8'h42;
    localparam logic [7:0] CMD_UV_WARN = 8'h43;
    localparam logic [7:0] CMD_UV_FAULT = 8'h44;
    localparam logic [7:0] CMD_UV_ACTION = 8'h45;

    // Threshold codes are volts times 2 to the power 13.
    localparam int LIN_EXPONENT = -13;

    // Strap multipliers in units of 1/1024.
    localparam int SCALE_SHIFT = 10;
    localparam logic [10:0] SCALE_OV_WARN = 11'h452;
    localparam logic [10:0] SCALE_UV_WARN = 11'h39a;
    localparam logic [10:0] SCALE_UV_FAULT = 11'h366;

    localparam int ACT_MODE_HI = 7;
    localparam int ACT_MODE_LO = 6;
    localparam int ACT_RETRY_HI = 5;
    localparam int ACT_RETRY_LO = 3;
    localparam int ACT_DELAY_HI = 2;
    localparam int ACT_DELAY_LO = 0;
    localparam logic [1:0] ACT_MODE_RETRY = 2'h2;
    localparam logic [2:0] ACT_RETRY_NONE = 3'h0;

    localparam int SV_OV_WARN = 6;
    localparam int SV_UV_WARN = 5;
    localparam int SV_UV_FAULT = 4;

    localparam int CLK_HZ = 50_000_000;
    localparam int RETRY_UNIT_MS = 35;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * (CLK_HZ / 1000);
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
    localparam int TIMER_WIDTH = 32;

    typedef struct packed {
        logic [15:0] ov_warn;
        logic [15:0] uv_warn;
        logic [15:0] uv_fault;
        logic [7:0] uv_action;
    } vlfm_limits_t;

    typedef struct packed {
        logic ramping;
        logic output_good_flag;
        logic commanded_on;
        logic bias_ok;
        logic other_shutdown;
    } vlfm_rail_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] wdata;
    } vlfm_cmd_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_LATCHED,
        ST_WAIT_DELAY,
        ST_TON
    } vlfm_state_t;
endpackage : vlfm_pkg

//--- rtl/vlfm_timer.sv
/*
 * Down-counting delay timer used for retry spacing and the turn-on delay.
 * It assumes start is a one-cycle strobe from logic on the same clock.
 */
`timescale 1ns/100ps
module vlfm_timer #(
    parameter int CW = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic start,
    input wire logic [CW-1:0] load,
    // Result
    output logic done_r,
    output logic busy_r
);
    logic [CW-1:0] cnt_r;

    // A zero load still takes one cycle, so done still pulses two cycles after start.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= (load == '0) ? CW'(1) : load;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            done_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            done_r <= !start && (cnt_r == CW'(1));
            busy_r <= start || (cnt_r > CW'(1));
        end
    end
endmodule : vlfm_timer

//--- rtl/vlfm_monitor.sv
/*
 * Output-voltage limit monitor with the undervoltage fault response sequencer.
 * It assumes samples, rail state and command strobes come from logic on clk_sys,
 * while the two strap buses are pins and are synchronised here.
 */
`timescale 1ns/100ps
module vlfm_monitor #(
    parameter int RETRY_UNIT = vlfm_pkg::RETRY_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Command port
    input wire vlfm_pkg::vlfm_cmd_t cmd,
    input wire logic clear_faults,
    output logic [15:0] rdata_r,
    output logic rvalid_r,
    // Measurement
    input wire logic [15:0] vout_sample,
    input wire logic vout_sample_valid,
    // Rail state
    input wire vlfm_pkg::vlfm_rail_t rail,
    input wire logic [23:0] ton_delay_cycles,
    input wire logic ov_fault_retry_req,
    // Straps
    input wire logic [15:0] setpoint_strap_pin,
    input wire logic [7:0] config_strap_pin,
    // Status and control
    output logic [7:0] status_vout_r,
    output logic status_word_vout_r,
    output logic host_alert_line_out,
    output logic host_alert_line_oe,
    output logic output_allow_r,
    output logic ov_retry_permit_r,
    output logic limits_ready_r
);
    localparam int TW = vlfm_pkg::TIMER_WIDTH;

    function automatic logic [15:0] scale_limit(input logic [15:0] sp, input logic [10:0] k);
        logic [26:0] p;
        p = 27'(sp) * 27'(k);
        scale_limit = p[26] ? 16'hffff : p[25:10];
    endfunction : scale_limit

    function automatic logic [TW-1:0] retry_cycles(input logic [2:0] field);
        retry_cycles = TW'((int'(field) + 1) * RETRY_UNIT);
    endfunction : retry_cycles

    vlfm_pkg::vlfm_limits_t limits_r;
    vlfm_pkg::vlfm_state_t state_r;
    vlfm_pkg::vlfm_state_t state_nxt;
    logic [15:0] sp_s1_r;
    logic [15:0] sp_s2_r;
    logic [7:0] cfg_s1_r;
    logic [7:0] cfg_s2_r;
    logic [1:0] settle_r;
    logic tmr_start;
    logic [TW-1:0] tmr_load;
    logic tmr_done;
    logic uv_unmasked;
    logic ov_warn_evt;
    logic uv_warn_evt;
    logic uv_fault_evt;
    logic stop_cond;
    logic [1:0] act_mode;
    logic [2:0] act_retry;
    logic [2:0] act_delay;
    logic [7:0] evt_bits;

    assign act_mode = limits_r.uv_action[vlfm_pkg::ACT_MODE_HI:vlfm_pkg::ACT_MODE_LO];
    assign act_retry = limits_r.uv_action[vlfm_pkg::ACT_RETRY_HI:vlfm_pkg::ACT_RETRY_LO];
    assign act_delay = limits_r.uv_action[vlfm_pkg::ACT_DELAY_HI:vlfm_pkg::ACT_DELAY_LO];

    // Straps are pins and pass two flip-flops before use.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sp_s1_r <= 16'h0;
            sp_s2_r <= 16'h0;
            cfg_s1_r <= 8'h0;
            cfg_s2_r <= 8'h0;
        end else begin
            sp_s1_r <= setpoint_strap_pin;
            sp_s2_r <= sp_s1_r;
            cfg_s1_r <= config_strap_pin;
            cfg_s2_r <= cfg_s1_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            settle_r <= 2'h0;
        end else if (settle_r != vlfm_pkg::STRAP_SETTLE_CYCLES) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    // Limits are loaded once from the straps, then follow host writes.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            limits_r <= '0;
            limits_ready_r <= 1'b0;
        end else if (!limits_ready_r) begin
            if (settle_r == vlfm_pkg::STRAP_SETTLE_CYCLES) begin
                limits_r.ov_warn <= scale_limit(sp_s2_r, vlfm_pkg::SCALE_OV_WARN);
                limits_r.uv_warn <= scale_limit(sp_s2_r, vlfm_pkg::SCALE_UV_WARN);
                limits_r.uv_fault <= scale_limit(sp_s2_r, vlfm_pkg::SCALE_UV_FAULT);
                limits_r.uv_action <= cfg_s2_r;
                limits_ready_r <= 1'b1;
            end
        end else if (cmd.wr) begin
            // Thresholds are stored as full 16-bit unsigned codes.
            case (cmd.code)
                vlfm_pkg::CMD_OV_WARN: limits_r.ov_warn <= cmd.wdata;
                vlfm_pkg::CMD_UV_WARN: limits_r.uv_warn <= cmd.wdata;
                vlfm_pkg::CMD_UV_FAULT: limits_r.uv_fault <= cmd.wdata;
                vlfm_pkg::CMD_UV_ACTION: limits_r.uv_action <= cmd.wdata[7:0];
                default: limits_r <= limits_r;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= 16'h0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= cmd.rd;
            if (cmd.rd) begin
                case (cmd.code)
                    vlfm_pkg::CMD_OV_WARN: rdata_r <= limits_r.ov_warn;
                    vlfm_pkg::CMD_UV_WARN: rdata_r <= limits_r.uv_warn;
                    vlfm_pkg::CMD_UV_FAULT: rdata_r <= limits_r.uv_fault;
                    vlfm_pkg::CMD_UV_ACTION: rdata_r <= {8'h0, limits_r.uv_action};
                    default: rdata_r <= 16'h0;
                endcase
            end
        end
    end

    // Low-side detection only counts while the rail is up and steady.
    assign uv_unmasked = rail.output_good_flag && !rail.ramping && rail.commanded_on
        && output_allow_r && (state_r == vlfm_pkg::ST_RUN);
    // Every sample above the band records the warning; skipping it would also be allowed.
    assign ov_warn_evt = limits_ready_r && vout_sample_valid
        && (vout_sample > limits_r.ov_warn);
    assign uv_warn_evt = limits_ready_r && vout_sample_valid && uv_unmasked
        && (vout_sample < limits_r.uv_warn);
    assign uv_fault_evt = limits_ready_r && vout_sample_valid && uv_unmasked
        && (vout_sample < limits_r.uv_fault);
    assign stop_cond = !rail.commanded_on || !rail.bias_ok || rail.other_shutdown;

    always_comb begin
        evt_bits = 8'h0;
        evt_bits[vlfm_pkg::SV_OV_WARN] = ov_warn_evt;
        evt_bits[vlfm_pkg::SV_UV_WARN] = uv_warn_evt;
        evt_bits[vlfm_pkg::SV_UV_FAULT] = uv_fault_evt;
    end

    // Status bits are sticky; a new event in the clearing cycle wins.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_vout_r <= 8'h0;
            status_word_vout_r <= 1'b0;
            host_alert_line_oe <= 1'b0;
        end else begin
            status_vout_r <= (clear_faults ? 8'h0 : status_vout_r)
                | evt_bits;
            status_word_vout_r <= (status_word_vout_r && !clear_faults)
                || ov_warn_evt || uv_warn_evt || uv_fault_evt;
            host_alert_line_oe <= (host_alert_line_oe && !clear_faults)
                || ov_warn_evt || uv_warn_evt || uv_fault_evt;
        end
    end

    // The alert pin is open drain and only ever pulled low.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            host_alert_line_out <= 1'b0;
        end else begin
            host_alert_line_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ov_retry_permit_r <= 1'b0;
        end else if (!ov_fault_retry_req) begin
            ov_retry_permit_r <= 1'b0;
        end else if (vout_sample_valid) begin
            ov_retry_permit_r <= vout_sample < limits_r.ov_warn;
        end
    end

    always_comb begin
        state_nxt = state_r;
        tmr_start = 1'b0;
        tmr_load = '0;
        case (state_r)
            vlfm_pkg::ST_RUN: begin
                if (uv_fault_evt && (act_mode == vlfm_pkg::ACT_MODE_RETRY)) begin
                    if (act_retry == vlfm_pkg::ACT_RETRY_NONE) begin
                        state_nxt = vlfm_pkg::ST_LATCHED;
                    end else begin
                        state_nxt = vlfm_pkg::ST_WAIT_DELAY;
                        tmr_start = 1'b1;
                        tmr_load = retry_cycles(act_delay);
                    end
                end
            end
            vlfm_pkg::ST_LATCHED: begin
                if (clear_faults) begin
                    state_nxt = vlfm_pkg::ST_RUN;
                end
            end
            vlfm_pkg::ST_WAIT_DELAY: begin
                if (stop_cond) begin
                    state_nxt = vlfm_pkg::ST_RUN;
                end else if (tmr_done) begin
                    state_nxt = vlfm_pkg::ST_TON;
                    tmr_start = 1'b1;
                    tmr_load = TW'(ton_delay_cycles);
                end
            end
            vlfm_pkg::ST_TON: begin
                if (stop_cond || tmr_done) begin
                    state_nxt = vlfm_pkg::ST_RUN;
                end
            end
            default: state_nxt = vlfm_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= vlfm_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // The output stays off from the fault until the sequence returns to run.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            output_allow_r <= 1'b1;
        end else begin
            output_allow_r <= (state_nxt == vlfm_pkg::ST_RUN);
        end
    end

    vlfm_timer #(
        .CW(TW)
    ) u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(tmr_start),
        .load(tmr_load),
        .done_r(tmr_done),
        .busy_r()
    );

    // Helper logic for the checks below.
    logic [TW-1:0] wait_cnt_r;
    logic [TW-1:0] wait_target_r;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wait_cnt_r <= '0;
            wait_target_r <= '0;
        end else if (state_r != vlfm_pkg::ST_WAIT_DELAY) begin
            wait_cnt_r <= '0;
            wait_target_r <= tmr_load;
        end else begin
            wait_cnt_r <= wait_cnt_r + TW'(1);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    property p_ov_warn_set;
        ov_warn_evt |=> status_vout_r[vlfm_pkg::SV_OV_WARN] && status_word_vout_r
            && host_alert_line_oe;
    endproperty
    a_ov_warn_set: assert property (p_ov_warn_set) else $error("high warning not flagged");

    property p_uv_warn_set;
        uv_warn_evt |=> status_vout_r[vlfm_pkg::SV_UV_WARN] && status_word_vout_r;
    endproperty
    a_uv_warn_set: assert property (p_uv_warn_set) else $error("low warning not flagged");

    property p_uv_fault_set;
        (vout_sample_valid && limits_ready_r && uv_unmasked
            && vout_sample < limits_r.uv_fault)
            |=> status_vout_r[vlfm_pkg::SV_UV_FAULT] && host_alert_line_oe;
    endproperty
    a_uv_fault_set: assert property (p_uv_fault_set) else $error("low fault not flagged");

    property p_uv_masked;
        (!rail.output_good_flag && !status_vout_r[vlfm_pkg::SV_UV_FAULT])
            |=> !status_vout_r[vlfm_pkg::SV_UV_FAULT];
    endproperty
    a_uv_masked: assert property (p_uv_masked) else $error("low fault seen while masked");

    property p_fault_sticky;
        (status_vout_r[vlfm_pkg::SV_UV_FAULT] && !clear_faults)
            |=> status_vout_r[vlfm_pkg::SV_UV_FAULT] && host_alert_line_oe;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault bit lost");

    property p_latched_off;
        (state_r == vlfm_pkg::ST_LATCHED) && !clear_faults |=> !output_allow_r;
    endproperty
    a_latched_off: assert property (p_latched_off) else $error("latched output came back");

    property p_stop_retry;
        ((state_r == vlfm_pkg::ST_WAIT_DELAY) && stop_cond)
            |=> (state_r == vlfm_pkg::ST_RUN) ##1 (state_r == vlfm_pkg::ST_RUN);
    endproperty
    a_stop_retry: assert property (p_stop_retry) else $error("retry did not stop");

    property p_retry_spacing;
        ((state_r == vlfm_pkg::ST_WAIT_DELAY) && (state_nxt == vlfm_pkg::ST_TON))
            |-> (wait_cnt_r == wait_target_r);
    endproperty
    a_retry_spacing: assert property (p_retry_spacing) else $error("retry spacing wrong");

    property p_ton_holds_off;
        (state_r == vlfm_pkg::ST_TON) |-> !output_allow_r;
    endproperty
    a_ton_holds_off: assert property (p_ton_holds_off) else $error("enabled before turn-on");

    property p_ov_permit;
        (vout_sample_valid && vout_sample >= limits_r.ov_warn) |=> !ov_retry_permit_r;
    endproperty
    a_ov_permit: assert property (p_ov_permit) else $error("overvoltage retry too early");

    property p_strap_load;
        $rose(limits_ready_r) |-> (limits_r.uv_action == $past(cfg_s2_r));
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("action not from strap");

    property p_unused_mode;
        (uv_fault_evt && act_mode != vlfm_pkg::ACT_MODE_RETRY) |=> output_allow_r;
    endproperty
    a_unused_mode: assert property (p_unused_mode) else $error("unused mode disabled output");

    c_latch: cover property ((state_r == vlfm_pkg::ST_RUN) ##1 (state_r == vlfm_pkg::ST_LATCHED));
    c_retry: cover property ((state_r == vlfm_pkg::ST_TON) ##1 (state_r == vlfm_pkg::ST_RUN));
    c_ov_warn: cover property (ov_warn_evt ##[1:8] clear_faults);
endmodule : vlfm_monitor

//--- test/vlfm_host_model.sv
/*
 * Host-side command model: issues threshold writes, reads and clear-faults strobes.
 * It assumes the monitor takes each strobe on the rising edge of clk_sys.
 */
`timescale 1ns/100ps
module vlfm_host_model (
    // Clock
    input wire logic clk_sys,
    // Command strobes
    output vlfm_pkg::vlfm_cmd_t cmd,
    output logic clear_faults
);
    initial begin
        cmd = '0;
        clear_faults = 1'b0;
    end

    // Released data lines show the inverse so stale values never look valid.
    task automatic write(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_sys);
        cmd = '{wr: 1'b1, rd: 1'b0, code: code, wdata: data};
        @(negedge clk_sys);
        cmd = '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~data};
    endtask : write

    task automatic read(input logic [7:0] code);
        @(negedge clk_sys);
        cmd = '{wr: 1'b0, rd: 1'b1, code: code, wdata: 16'h0000};
        @(negedge clk_sys);
        cmd = '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: 16'hffff};
    endtask : read

    task automatic clear();
        @(negedge clk_sys);
        clear_faults = 1'b1;
        @(negedge clk_sys);
        clear_faults = 1'b0;
    endtask : clear
endmodule : vlfm_host_model

//--- test/tb_vlfm_monitor.sv
/*
 * Self-checking bench for the limit monitor: reads go through a queue of expected data.
 * It assumes a shortened retry unit and fixed strap pins for the whole run.
 */
`timescale 1ns/100ps
module tb_vlfm_monitor;
    localparam int RU = 20;
    localparam int TON = 5;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    vlfm_pkg::vlfm_cmd_t cmd;
    logic clear_faults;
    logic [15:0] rdata_r;
    logic rvalid_r;
    logic [15:0] vout_sample = 16'h2000;
    logic vout_sample_valid = 1'b0;
    vlfm_pkg::vlfm_rail_t rail = 5'h0e;
    logic ov_fault_retry_req = 1'b0;
    logic [7:0] status_vout_r;
    logic status_word_vout_r;
    logic host_alert_line_out;
    logic host_alert_line_oe;
    logic output_allow_r;
    logic ov_retry_permit_r;
    logic limits_ready_r;
    logic [15:0] exp_q[$];
    logic [15:0] r;
    logic [4:0] mask_tab[3] = '{5'h06, 5'h1e, 5'h0a};
    logic [4:0] stop_tab[3] = '{5'h0a, 5'h0c, 5'h0f};
    logic [7:0] act_tab[3] = '{8'h00, 8'h40, 8'hc0};
    int err_count = 0;
    int num_checks = 0;
    int n;
    int c;
    int unsigned seed_val;

    always #10 clk_sys = ~clk_sys;

    vlfm_host_model i_host (.clk_sys(clk_sys), .cmd(cmd), .clear_faults(clear_faults));

    vlfm_monitor #(.RETRY_UNIT(RU)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .cmd(cmd), .clear_faults(clear_faults),
        .rdata_r(rdata_r), .rvalid_r(rvalid_r), .vout_sample(vout_sample),
        .vout_sample_valid(vout_sample_valid), .rail(rail), .ton_delay_cycles(24'(TON)),
        .ov_fault_retry_req(ov_fault_retry_req), .setpoint_strap_pin(16'h2000),
        .config_strap_pin(8'h90), .status_vout_r(status_vout_r),
        .status_word_vout_r(status_word_vout_r), .host_alert_line_out(host_alert_line_out),
        .host_alert_line_oe(host_alert_line_oe), .output_allow_r(output_allow_r),
        .ov_retry_permit_r(ov_retry_permit_r), .limits_ready_r(limits_ready_r)
    );

    task automatic end_of_test();
        $display("Checks made: %0d, mismatches: %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] obs();
        return {4'h0, host_alert_line_out, output_allow_r, host_alert_line_oe,
            status_word_vout_r, status_vout_r};
    endfunction : obs

    // Alert line and summary bit follow any sticky status bit.
    function automatic logic [15:0] st(input logic [7:0] v, input logic allow);
        return {4'h0, 1'b0, allow, |v, |v, v};
    endfunction : st

    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        exp_q.push_back(exp);
        i_host.read(code);
    endtask : rd

    task automatic sample(input logic [15:0] v);
        @(negedge clk_sys);
        vout_sample = v;
        vout_sample_valid = 1'b1;
        @(negedge clk_sys);
        vout_sample_valid = 1'b0;
        @(negedge clk_sys);
    endtask : sample

    task automatic clr();
        i_host.clear();
        @(negedge clk_sys);
    endtask : clr

    task automatic wait_allow(output int cnt);
        cnt = 0;
        while (output_allow_r !== 1'b1) begin
            cnt++;
            if (cnt > 400) begin
                err_count++;
                end_of_test();
            end
            @(negedge clk_sys);
        end
    endtask : wait_allow

    always @(negedge clk_sys) begin
        if (rvalid_r === 1'b1)
            check(rdata_r, (exp_q.size() > 0) ? exp_q.pop_front() : ~rdata_r);
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        end_of_test();
    end

    initial begin
        seed_val = $urandom(32'hf0c7);
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        // A write before the strap defaults are loaded must be ignored.
        i_host.write(vlfm_pkg::CMD_OV_WARN, 16'h1234);
        wait_allow(c);
        repeat (4) @(negedge clk_sys);
        check({15'h0, limits_ready_r}, 16'h0001);
        check(obs(), st(8'h00, 1'b1));
        rd(vlfm_pkg::CMD_OV_WARN, 16'h2290);
        rd(vlfm_pkg::CMD_UV_WARN, 16'h1cd0);
        rd(vlfm_pkg::CMD_UV_FAULT, 16'h1b30);
        rd(vlfm_pkg::CMD_UV_ACTION, 16'h0090);
        rd(8'h46, 16'h0000);
        for (n = 0; n < 4; n++) begin
            r = 16'($urandom);
            i_host.write(vlfm_pkg::CMD_OV_WARN + 8'(n), r);
            rd(vlfm_pkg::CMD_OV_WARN + 8'(n), (n == 3) ? {8'h00, r[7:0]} : r);
        end
        // Thresholds restored in the required order: low fault below low warning below high warning.
        i_host.write(vlfm_pkg::CMD_OV_WARN, 16'h2290);
        i_host.write(vlfm_pkg::CMD_UV_WARN, 16'h1cd0);
        i_host.write(vlfm_pkg::CMD_UV_FAULT, 16'h1b30);
        sample(16'h2290);
        check(obs(), st(8'h00, 1'b1));
        sample(16'h2291);
        check(obs(), st(8'h40, 1'b1));
        clr();
        check(obs(), st(8'h00, 1'b1));
        for (n = 0; n < 3; n++) begin
            rail = mask_tab[n];
            sample(16'h0100);
            check(obs(), st(8'h00, 1'b1));
        end
        rail = 5'h0e;
        sample(16'h1c00);
        check(obs(), st(8'h20, 1'b1));
        clr();
        for (n = 0; n < 3; n++) begin
            i_host.write(vlfm_pkg::CMD_UV_ACTION, {8'h00, act_tab[n]});
            sample(16'h1000);
            check(obs(), st(8'h30, 1'b1));
            clr();
        end
        i_host.write(vlfm_pkg::CMD_UV_ACTION, 16'h0080);
        sample(16'h1000);
        repeat (100) @(negedge clk_sys);
        check(obs(), st(8'h30, 1'b0));
        clr();
        check(obs(), st(8'h00, 1'b1));
        for (n = 0; n < 2; n++) begin
            i_host.write(vlfm_pkg::CMD_UV_ACTION, {8'h00, 2'b10, 3'h1, 3'(2 * n + 1)});
            sample(16'h1000);
            check(obs(), st(8'h30, 1'b0));
            wait_allow(c);
            c = c + 1 - (2 * n + 2) * RU - TON;
            check({15'h0, (c >= 0 && c <= 3)}, 16'h0001);
            sample(16'h1000);
            check(obs(), st(8'h30, 1'b0));
            wait_allow(c);
            c = c + 1 - (2 * n + 2) * RU - TON;
            check({15'h0, (c >= 0 && c <= 3)}, 16'h0001);
            clr();
        end
        for (n = 0; n < 3; n++) begin
            i_host.write(vlfm_pkg::CMD_UV_ACTION, 16'h008f);
            sample(16'h1000);
            repeat (5) @(negedge clk_sys);
            rail = stop_tab[n];
            repeat (2) @(negedge clk_sys);
            check(obs(), st(8'h30, 1'b1));
            rail = 5'h0e;
            clr();
        end
        ov_fault_retry_req = 1'b1;
        sample(16'h2000);
        check({15'h0, ov_retry_permit_r}, 16'h0001);
        sample(16'h2300);
        check({15'h0, ov_retry_permit_r}, 16'h0000);
        check(obs(), st(8'h40, 1'b1));
        ov_fault_retry_req = 1'b0;
        clr();
        repeat (3) @(negedge clk_sys);
        check(16'(exp_q.size()), 16'h0000);
        end_of_test();
    end
endmodule : tb_vlfm_monitor
